//--- rsc_pkg.sv
// Purpose: Constants and types shared by the reset source combiner.
// Assumes: APB with 32-bit data, registers on aligned words.
// Notes:   Offsets are byte addresses.
`default_nettype none
package rsc_pkg;

   localparam int unsigned ADDR_W = 12;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_OSC_CONTROL        = 12'h004;

   // Field positions in reset_cause_status
   localparam int unsigned BIT_TRAP_CONFLICT   = 15;
   localparam int unsigned BIT_ILLEGAL_COND    = 14;
   localparam int unsigned BIT_CONFIG_MISMATCH = 9;
   localparam int unsigned BIT_REG_SLEEP_ACT   = 8;
   localparam int unsigned BIT_PIN_RESET       = 7;
   localparam int unsigned BIT_INSTR_RESET     = 6;
   localparam int unsigned BIT_WATCHDOG        = 4;
   localparam int unsigned BIT_SLEEP_WAKE      = 3;
   localparam int unsigned BIT_IDLE_WAKE       = 2;
   localparam int unsigned BIT_BROWNOUT        = 1;
   localparam int unsigned BIT_POWER_ON        = 0;

   // Bits 13..10 unimplemented, bit 5 reserved
   localparam logic [15:0] STATUS_IMPL_MASK = 16'hC3DF;
   localparam logic [15:0] STATUS_POR_VALUE = 16'h0003;

   // next_osc_select position in the oscillator control word
   localparam int unsigned OSC_SEL_LSB = 8;
   localparam int unsigned OSC_SEL_W   = 3;
   localparam logic [OSC_SEL_W-1:0] OSC_SEL_POR_VALUE = 3'h0;

   // Pin synchroniser depth
   localparam int unsigned SYNC_STAGES = 3;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] brownout_sync;
      logic [SYNC_STAGES-1:0] master_clear_pin_n_sync;
      logic                   brownout_lvl;
      logic                   master_clear_pin_n_lvl;
      logic                   master_rst;
      logic [15:0]            status;
      logic [OSC_SEL_W-1:0]   osc_sel;
      logic [31:0]            rdata;
      logic                   slverr;
   } rsc_state_t;

endpackage
`default_nettype wire

//--- rsc_top.sv
// Purpose: Reset source combiner: merges all reset sources into one
//          master system reset and records the cause for software.
// Assumes: arst_n_i is the power-on reset; brown-out and master-clear
//          arrive asynchronously from pins, all others from mclk_i logic.
// Notes:   The status register is not cleared by the master reset, only
//          by power-on, so the cause survives the reset it reports.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [R1] Any active source asserts master system reset
// [R2] Ten reset sources feed the combiner
// [R3] Each reset kind sets its own status flag; here security reset sets no flag
// [R4] Power-on clears flags, sets brown-out and power-on
// [R5] Software sets or clears flags, no reset
// [R6] Reset loads default oscillator select into control
// [R7] Reset forces some registers, others keep contents
// [R8] Bit 15 records trap-conflict reset
// [R9] Bit 14 records illegal opcode, mode, pointer
// [R10] Bit 9 records configuration-mismatch reset
// [R11] Bit 8 keeps regulator active in sleep
// [R12] Bit 7 records master-clear pin reset
// [R13] Bit 6 records reset instruction
// [R14] Bit 4 records watchdog time-out
// [R15] Bit 3 records having been in sleep
// [R16] Bit 2 records having been in idle
// [R17] Bit 1 records brown-out reset
// [R18] Bit 0 records power-on reset
// [R19] Bits 13 to 10 and 5 read zero
// [R20] Software should clear flags after reading
// [R21] Master reset releases synchronously after sources idle
module rsc_top
(
   input  wire  logic                                mclk_i,
   input  wire  logic                                arst_n_i,
   // APB slave
   input  wire  logic                                psel_i,
   input  wire  logic                                penable_i,
   input  wire  logic                                pwrite_i,
   input  wire  logic [rsc_pkg::ADDR_W-1:0]          paddr_i,
   input  wire  logic [31:0]                         pwdata_i,
   input  wire  logic [3:0]                          pstrb_i,
   output logic                                      pready_o,
   output logic [31:0]                               prdata_o,
   output logic                                      pslverr_o,
   // Reset sources
   input  wire  logic                                brownout_i,
   input  wire  logic                                master_clear_pin_n_i,
   input  wire  logic                                reset_instr_i,
   input  wire  logic                                watchdog_timeout_i,
   input  wire  logic                                config_mismatch_i,
   input  wire  logic                                trap_conflict_i,
   input  wire  logic                                illegal_opcode_i,
   input  wire  logic                                illegal_addr_mode_i,
   input  wire  logic                                uninit_wreg_i,
   input  wire  logic                                security_reset_i,
   // Power-saving events
   input  wire  logic                                sleep_wake_i,
   input  wire  logic                                idle_wake_i,
   // Configuration
   input  wire  logic [rsc_pkg::OSC_SEL_W-1:0]       default_osc_select_i,
   // Outputs
   output logic                                      master_system_reset_o,
   output logic [rsc_pkg::OSC_SEL_W-1:0]             next_osc_select_o,
   output logic                                      regulator_sleep_active_o
);
   import rsc_pkg::*;

   rsc_state_t st;
   rsc_state_t next_st;

   logic        any_source;
   logic        brownout_filt;
   logic        master_clear_pin_n_filt;
   logic        illegal_any;
   logic        setup_phase;
   logic        access_phase;
   logic        hit_status;
   logic        hit_osc;
   logic        do_write;
   logic [15:0] wr_mask;
   logic [15:0] sw_status;
   logic [15:0] hw_set;
   logic [31:0] osc_word;
   logic        src_brownout;
   logic        src_pin;
   logic        src_instr;
   logic        src_watchdog;
   logic        src_mismatch;
   logic        src_trap;
   logic        src_illegal;
   logic        src_security;
   logic        evt_sleep;
   logic        evt_idle;
   logic        rd_hit;
   logic [31:0] rd_word;
   logic        osc_wr;
   logic [OSC_SEL_W-1:0] osc_wr_val;
   logic [15:0] next_status;

   // Bus answers in the access phase without wait states
   assign pready_o                 = 1'b1;
   assign prdata_o                 = st.rdata;
   assign pslverr_o                = st.slverr;
   assign master_system_reset_o    = st.master_rst;
   assign next_osc_select_o        = st.osc_sel;
   assign regulator_sleep_active_o = st.status[BIT_REG_SLEEP_ACT]; // [R11]

   assign setup_phase  = psel_i & ~penable_i;
   assign access_phase = psel_i & penable_i;
   assign hit_status   = (paddr_i == OFS_RESET_CAUSE_STATUS);
   assign hit_osc      = (paddr_i == OFS_OSC_CONTROL);
   assign do_write     = access_phase & pwrite_i;
   assign wr_mask      = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign osc_wr_val   = pwdata_i[OSC_SEL_LSB +: OSC_SEL_W];

   // The oscillator field sits in byte lane 1 only
   always_comb
   begin
      osc_wr = 1'b0;
      if (do_write && hit_osc && pstrb_i[1])
      begin
         osc_wr = 1'b1;
      end
   end

   always_comb
   begin
      osc_word                       = 32'h0000_0000;
      osc_word[OSC_SEL_LSB +: OSC_SEL_W] = st.osc_sel;
   end

   // Pin levels change only once the last two stages agree
   always_comb
   begin
      if (st.brownout_sync[2] == st.brownout_sync[1])
      begin
         brownout_filt = st.brownout_sync[2];
      end
      else
      begin
         brownout_filt = st.brownout_lvl;
      end
      if (st.master_clear_pin_n_sync[2] == st.master_clear_pin_n_sync[1])
      begin
         master_clear_pin_n_filt = st.master_clear_pin_n_sync[2];
      end
      else
      begin
         master_clear_pin_n_filt = st.master_clear_pin_n_lvl;
      end
   end

   // Three CPU faults share one flag
   always_comb
   begin
      illegal_any = 1'b0;
      if (illegal_opcode_i || illegal_addr_mode_i || uninit_wreg_i)
      begin
         illegal_any = 1'b1; // [R9]
      end
   end

   // Pin sources count only after the filter, so a glitch cannot reset
   assign src_brownout = st.brownout_lvl;     // [R2]
   assign src_pin      = ~st.master_clear_pin_n_lvl;      // [R2]
   assign src_instr    = reset_instr_i;       // [R2]
   assign src_watchdog = watchdog_timeout_i;  // [R2]
   assign src_mismatch = config_mismatch_i;   // [R2]
   assign src_trap     = trap_conflict_i;     // [R2]
   assign src_illegal  = illegal_any;         // [R2]
   assign src_security = security_reset_i;    // [R2]
   assign evt_sleep    = sleep_wake_i;
   assign evt_idle     = idle_wake_i;

   // Every source feeds the one reset; security reset has no flag
   always_comb
   begin
      any_source = 1'b0;
      if (src_brownout || src_pin)
      begin
         any_source = 1'b1; // [R1]
      end
      if (src_instr || src_watchdog || src_mismatch)
      begin
         any_source = 1'b1; // [R1]
      end
      if (src_trap || src_illegal || src_security)
      begin
         any_source = 1'b1; // [R1]
      end
   end

   // Hardware set terms, one per flag except power-on and regulator bit 8
   always_comb
   begin
      hw_set                      = 16'h0000;
      hw_set[BIT_TRAP_CONFLICT]   = src_trap;            // [R3] [R8]
      hw_set[BIT_ILLEGAL_COND]    = src_illegal;         // [R3] [R9]
      hw_set[BIT_CONFIG_MISMATCH] = src_mismatch;        // [R3] [R10]
      hw_set[BIT_PIN_RESET]       = src_pin;             // [R3] [R12]
      hw_set[BIT_INSTR_RESET]     = src_instr;           // [R3] [R13]
      hw_set[BIT_WATCHDOG]        = src_watchdog;        // [R3] [R14]
      hw_set[BIT_SLEEP_WAKE]      = evt_sleep;           // [R15]
      hw_set[BIT_IDLE_WAKE]       = evt_idle;            // [R16]
      hw_set[BIT_BROWNOUT]        = src_brownout;        // [R3] [R17]
   end

   // Software write image; a write only stores, it never causes a reset
   always_comb
   begin
      sw_status = st.status;
      if (do_write && hit_status)
      begin
         sw_status = (st.status & ~wr_mask) | (pwdata_i[15:0] & wr_mask); // [R5]
      end
   end

   // A hardware set wins over a software clear in the same cycle
   always_comb
   begin
      next_status = sw_status;

      if (hw_set[BIT_TRAP_CONFLICT])
      begin
         next_status[BIT_TRAP_CONFLICT] = 1'b1; // [R8]
      end
      if (hw_set[BIT_ILLEGAL_COND])
      begin
         next_status[BIT_ILLEGAL_COND] = 1'b1; // [R9]
      end
      if (hw_set[BIT_CONFIG_MISMATCH])
      begin
         next_status[BIT_CONFIG_MISMATCH] = 1'b1; // [R10]
      end

      if (hw_set[BIT_PIN_RESET])
      begin
         next_status[BIT_PIN_RESET] = 1'b1; // [R12]
      end
      if (hw_set[BIT_INSTR_RESET])
      begin
         next_status[BIT_INSTR_RESET] = 1'b1; // [R13]
      end
      if (hw_set[BIT_WATCHDOG])
      begin
         next_status[BIT_WATCHDOG] = 1'b1; // [R14]
      end

      if (hw_set[BIT_SLEEP_WAKE])
      begin
         next_status[BIT_SLEEP_WAKE] = 1'b1; // [R15]
      end
      if (hw_set[BIT_IDLE_WAKE])
      begin
         next_status[BIT_IDLE_WAKE] = 1'b1; // [R16]
      end

      if (hw_set[BIT_BROWNOUT])
      begin
         next_status[BIT_BROWNOUT] = 1'b1; // [R17]
      end
      next_status = next_status & STATUS_IMPL_MASK; // [R19]
   end

   // Read mux; unmapped addresses read zero and raise the error
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (paddr_i)
         OFS_RESET_CAUSE_STATUS:
         begin
            rd_word = {16'h0000, st.status & STATUS_IMPL_MASK}; // [R19]
         end
         OFS_OSC_CONTROL:
         begin
            rd_word = osc_word;
         end
         default:
         begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_st = st;

      next_st.brownout_sync = {st.brownout_sync[1:0], brownout_i};
      next_st.master_clear_pin_n_sync   = {st.master_clear_pin_n_sync[1:0], master_clear_pin_n_i};
      next_st.brownout_lvl  = brownout_filt;
      next_st.master_clear_pin_n_lvl    = master_clear_pin_n_filt;

      // Release is taken on a clock edge, so it never glitches downstream
      next_st.master_rst = any_source; // [R21]

      // Flags are merged and masked in next_status
      next_st.status = next_status; // [R3]

      // Oscillator select: software may change it, any reset reloads it
      if (osc_wr)
      begin
         next_st.osc_sel = osc_wr_val;
      end
      if (st.master_rst)
      begin
         next_st.osc_sel = default_osc_select_i; // [R6] [R7]
      end

      // Read data and error are captured in the setup phase
      if (setup_phase)
      begin
         next_st.slverr = ~rd_hit;
         next_st.rdata  = rd_word;
      end
      else if (!psel_i)
      begin
         next_st.slverr = 1'b0;
         next_st.rdata  = 32'h0000_0000;
      end
   end

   // Power-on: flags cleared except brown-out and power-on, reset held
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st.brownout_sync <= '0;
         st.master_clear_pin_n_sync   <= '1;
         st.brownout_lvl  <= 1'b0;
         st.master_clear_pin_n_lvl    <= 1'b1;
         st.master_rst    <= 1'b1;             // [R1]
         st.status        <= STATUS_POR_VALUE; // [R4] [R18] [R17]
         st.osc_sel       <= OSC_SEL_POR_VALUE;
         st.rdata         <= 32'h0000_0000;
         st.slverr        <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule
`default_nettype wire

//--- rsc_src_model.sv
// Purpose: Reset sources: supervisor, pin and CPU fault logic.
// Assumes: Index 0 brown-out, 1 pin, 2..9 same-clock resets, 10..11 wake events.
// Notes:   Pins hold 8 cycles so the synchroniser cannot miss them.
`timescale 1ns/10ps
`default_nettype none
module rsc_src_model
(
   input  wire logic       mclk_i,
   input  wire logic [3:0] sel_i,
   input  wire logic       go_i,
   output logic            brownout_o,
   output logic            master_clear_pin_n_o,
   output logic [9:0]      pulse_o
);
   logic [3:0] cnt = 4'h0;
   logic [3:0] sel = 4'h0;
   always @(posedge mclk_i)
   begin
      cnt <= go_i ? 4'h8 : ((cnt != 4'h0) ? cnt - 4'h1 : cnt);
      sel <= go_i ? sel_i : sel;
   end
   assign brownout_o = cnt != 4'h0 && sel == 4'h0;
   assign master_clear_pin_n_o   = !(cnt != 4'h0 && sel == 4'h1);
   assign pulse_o    = (cnt == 4'h8 && sel > 4'h1) ? 10'h001 << (sel - 4'h2) : 10'h000;
endmodule
`default_nettype wire

//--- rsc_top_props.sv
// Purpose: Port checker for the reset source combiner.
// Assumes: Bound to rsc_top.
// Notes:   Pins get 7 edges to cross the synchroniser.
`timescale 1ns/10ps
`default_nettype none
module rsc_top_props
(
   input wire logic        mclk_i,
   input wire logic        arst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        brownout_i,
   input wire logic        master_clear_pin_n_i,
   input wire logic        reset_instr_i,
   input wire logic        watchdog_timeout_i,
   input wire logic        config_mismatch_i,
   input wire logic        trap_conflict_i,
   input wire logic        illegal_opcode_i,
   input wire logic        illegal_addr_mode_i,
   input wire logic        uninit_wreg_i,
   input wire logic        security_reset_i,
   input wire logic [2:0]  default_osc_select_i,
   input wire logic        master_system_reset_o,
   input wire logic [2:0]  next_osc_select_o,
   input wire logic        regulator_sleep_active_o
);
   import rsc_pkg::*;
   logic any_src;
   assign any_src = reset_instr_i | watchdog_timeout_i | config_mismatch_i | trap_conflict_i
                  | illegal_opcode_i | illegal_addr_mode_i | uninit_wreg_i | security_reset_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   sequence status_wr_s;
      psel_i && penable_i && pwrite_i && pstrb_i[1] && paddr_i == OFS_RESET_CAUSE_STATUS;
   endsequence
   pready_high_a: assert property (pready_o) else $error("pready low");
   src_to_rst_a: assert property (any_src |=> master_system_reset_o)
      else $error("source without master reset");
   brown_rst_a: assert property (brownout_i [*7] |-> master_system_reset_o)
      else $error("brown-out without master reset");
   pin_rst_a: assert property (!master_clear_pin_n_i [*7] |-> master_system_reset_o)
      else $error("pin without master reset");
   rst_release_a: assert property ($fell(master_system_reset_o) |-> !$past(any_src))
      else $error("master reset fell with source active");
   osc_load_a: assert property (master_system_reset_o |=> next_osc_select_o == $past(default_osc_select_i))
      else $error("oscillator select not loaded");
   osc_keep_a: assert property (!master_system_reset_o && !(psel_i && penable_i && pwrite_i
      && paddr_i == OFS_OSC_CONTROL) |=> $stable(next_osc_select_o))
      else $error("oscillator select changed");
   unmapped_err_a: assert property (setup_s ##0 (!pwrite_i && paddr_i != OFS_RESET_CAUSE_STATUS
      && paddr_i != OFS_OSC_CONTROL) |=> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped read not refused");
   rsvd_zero_a: assert property (setup_s ##0 (!pwrite_i && paddr_i == OFS_RESET_CAUSE_STATUS) |=>
      (prdata_o & ~{16'h0000, STATUS_IMPL_MASK}) == 32'h0) else $error("unimplemented bits set");
   reg_bit_a: assert property (status_wr_s |=> regulator_sleep_active_o == $past(pwdata_i[8]))
      else $error("regulator bit not written");
endmodule
bind rsc_top rsc_top_props rsc_top_props_i (.*);
`default_nettype wire

//--- rsc_top_tb_top.sv
// Purpose: Self-checking bench for the reset source combiner.
// Assumes: Sources come from rsc_src_model; registers over APB.
// Notes:   Status is cleared by software before each source fires in t_sources.
`timescale 1ns/10ps
`default_nettype none
module rsc_top_tb_top;
   import rsc_pkg::*;
   logic        mclk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [3:0]  sel = 4'h0;
   logic [2:0]  dflt = 3'h5, nosc;
   logic        err, pready, pslverr, bo, master_clear_pin_n, mrst, vreg;
   logic [9:0]  pulse;
   int          num_errors = 0, check_count = 0, cyc = 0;
   logic [15:0] exp_tab [12] = '{16'h0002, 16'h0080, 16'h0040, 16'h0010, 16'h0200, 16'h8000,
                                  16'h4000, 16'h4000, 16'h4000, 16'h0000, 16'h0008, 16'h0004};
   always #12.5 mclk_i = ~mclk_i;
   rsc_src_model rsc_src_model_i (.mclk_i(mclk_i), .sel_i(sel), .go_i(go), .brownout_o(bo),
      .master_clear_pin_n_o(master_clear_pin_n), .pulse_o(pulse));
   rsc_top rsc_top_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .pready_o(pready),
      .prdata_o(prdata), .pslverr_o(pslverr), .brownout_i(bo), .master_clear_pin_n_i(master_clear_pin_n),
      .reset_instr_i(pulse[0]), .watchdog_timeout_i(pulse[1]), .config_mismatch_i(pulse[2]),
      .trap_conflict_i(pulse[3]), .illegal_opcode_i(pulse[4]), .illegal_addr_mode_i(pulse[5]),
      .uninit_wreg_i(pulse[6]), .security_reset_i(pulse[7]), .sleep_wake_i(pulse[8]),
      .idle_wake_i(pulse[9]), .default_osc_select_i(dflt), .master_system_reset_o(mrst),
      .next_osc_select_o(nosc), .regulator_sleep_active_o(vreg));
   task automatic report_and_stop;
      if (num_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk_i);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fire(input int i);
      logic seen;
      @(posedge mclk_i);
      sel <= i[3:0];
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      seen = 1'b0;
      repeat (30)
      begin
         @(posedge mclk_i);
         seen = seen | mrst;
      end
      chk(seen, i < 10);
      chk(mrst, 1'b0);
   endtask
   task automatic t_por;
      apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0);
      chk(rd, STATUS_POR_VALUE);
      apb(1'b0, OFS_OSC_CONTROL, 32'h0);
      chk(rd, {21'h0, dflt, 8'h00});
   endtask
   task automatic t_repor;
      apb(1'b1, OFS_RESET_CAUSE_STATUS, 32'h0000_0110);
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk(mrst, 1'b1);
      chk(nosc, OSC_SEL_POR_VALUE);
      arst_n_i <= 1'b1;
      apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0);
      chk(rd, STATUS_POR_VALUE);
      chk(vreg, 1'b0);
      chk(nosc, dflt);
   endtask
   task automatic t_software;
      apb(1'b1, OFS_RESET_CAUSE_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0);
      chk(rd, 32'h0000_C3DF);
      chk(vreg, 1'b1);
      chk(mrst, 1'b0);
      apb(1'b1, OFS_RESET_CAUSE_STATUS, 32'h0);
      apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(vreg, 1'b0);
   endtask
   task automatic t_sources;
      for (int i = 0; i < 12; i++)
      begin
         apb(1'b1, OFS_RESET_CAUSE_STATUS, 32'h0);
         fire(i);
         apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0);
         chk(rd, {16'h0, exp_tab[i]});
      end
   endtask
   task automatic t_osc;
      apb(1'b1, OFS_OSC_CONTROL, 32'h0000_0200);
      apb(1'b0, OFS_OSC_CONTROL, 32'h0);
      chk(rd, 32'h0000_0200);
      chk(nosc, 3'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      fire(3);
      chk(nosc, dflt);
      apb(1'b0, OFS_OSC_CONTROL, 32'h0);
      chk(rd, {21'h0, dflt, 8'h00});
   endtask
   initial
   begin
      repeat (20) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      t_por;
      t_software;
      t_sources;
      t_osc;
      t_repor;
      report_and_stop;
   end
endmodule
`default_nettype wire
